// [design/timer8_pkg.sv]
// Purpose: Shared constants and types of the 8-bit timer waveform block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one word per register
// Notes:   Each offset, field position and limit, and the control, compare and count reset values, are named here
package timer8_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL_A    = 8'h30;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h34;
    localparam logic [7:0] ADDR_CMP_A     = 8'h38;
    localparam logic [7:0] ADDR_CMP_B     = 8'h3c;
    localparam logic [7:0] ADDR_COUNT     = 8'h40;
    localparam logic [7:0] ADDR_FLAGS     = 8'h44;

    // Field positions
    localparam int         OUT_A_LSB      = 6;
    localparam int         OUT_B_LSB      = 4;
    localparam int         WAVE_LOW_LSB   = 0;
    localparam int         WAVE_HI_BIT    = 3;
    localparam int         FLAG_OVF_BIT   = 0;
    localparam int         FLAG_DIR_BIT   = 1;

    // Writable bits and reset values
    localparam logic [7:0] CTRL_A_WMASK   = 8'hf3;
    localparam logic [7:0] CTRL_B_WMASK   = 8'h08;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] CMP_RST        = 8'h00;
    localparam logic [7:0] COUNT_RST      = 8'h00;

    // Counter limits
    localparam logic [7:0] COUNT_MAX      = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM   = 8'h00;

    typedef enum logic [2:0] {
        WM_NORMAL   = 3'b000,
        WM_PC_FF    = 3'b001,
        WM_CTC      = 3'b010,
        WM_FAST_FF  = 3'b011,
        WM_RES4     = 3'b100,
        WM_PC_CMP   = 3'b101,
        WM_RES6     = 3'b110,
        WM_FAST_CMP = 3'b111
    } wave_mode_e;

    typedef enum logic [1:0] {
        OM_OFF    = 2'b00,
        OM_TOGGLE = 2'b01,
        OM_CLEAR  = 2'b10,
        OM_SET    = 2'b11
    } out_mode_e;

endpackage : timer8_pkg

// [design/wave_channel.sv]
// Purpose: One compare-output channel: drives a waveform pin and its enable
// Assumes: Mode class, match and top signals come from the counter core
// Notes:   TOGGLE_OK is 1 for channel A, 0 for channel B
`timescale 1ns/1ps
module wave_channel #(
    parameter bit TOGGLE_OK = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pwm_fast,
    input  wire logic       pwm_phase,
    input  wire logic       wave_mode_hi,
    input  wire logic [1:0] out_mode,
    input  wire logic       match,
    input  wire logic       at_top,
    input  wire logic       dir_down,
    input  wire logic       cmp_is_top,
    output logic            wave_out,
    output logic            wave_en
);

    logic wave_out_reg;
    logic wave_out_next;
    logic wave_en_reg;

    wire  pwm        = pwm_fast | pwm_phase;
    wire  toggle_pwm = TOGGLE_OK & wave_mode_hi;
    wire  is_toggle  = out_mode == timer8_pkg::OM_TOGGLE;
    wire  connect    = (out_mode != timer8_pkg::OM_OFF)
                       & ~(pwm & is_toggle & ~toggle_pwm);

    always_comb
    begin
        wave_out_next = wave_out_reg;
        if (!pwm)
        begin
            if (match)
            begin
                case (out_mode)
                    timer8_pkg::OM_TOGGLE: wave_out_next = ~wave_out_reg;
                    timer8_pkg::OM_CLEAR:  wave_out_next = 1'h0;
                    timer8_pkg::OM_SET:    wave_out_next = 1'h1;
                    default:               wave_out_next = wave_out_reg;
                endcase
            end
        end
        else if (is_toggle)
        begin
            if (toggle_pwm && match)
                wave_out_next = ~wave_out_reg;
        end
        else if (out_mode[1])
        begin
            if (pwm_fast)
            begin
                if (at_top)
                    wave_out_next = ~out_mode[0];
                else if (match && !cmp_is_top)
                    wave_out_next = out_mode[0];
            end
            else if (cmp_is_top)
            begin
                if (at_top)
                    wave_out_next = ~out_mode[0];
            end
            else if (match)
            begin
                wave_out_next = out_mode[0] ^ dir_down;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_out_reg <= 1'h0;
            wave_en_reg  <= 1'h0;
        end
        else
        begin
            wave_out_reg <= wave_out_next;
            wave_en_reg  <= connect;
        end
    end

    assign wave_out = wave_out_reg;
    assign wave_en  = wave_en_reg;

    a_off_disconnects: assert property (
        @(posedge clk) disable iff (!rst_n)
        out_mode == timer8_pkg::OM_OFF |=> !wave_en)
        else $error("Channel enabled with output mode off");

    a_nonpwm_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        !pwm && out_mode == timer8_pkg::OM_CLEAR && match |=> !wave_out)
        else $error("Non-PWM clear on match failed");

    a_fast_top_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        pwm_fast && out_mode == timer8_pkg::OM_CLEAR && at_top
        |=> wave_out)
        else $error("Fast PWM did not set output at top");

    a_phase_down_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        pwm_phase && out_mode == timer8_pkg::OM_CLEAR && match
        && dir_down && !cmp_is_top |=> wave_out)
        else $error("Phase PWM did not set on down match");

    a_pwm_toggle_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        pwm && is_toggle |=> wave_en == $past(toggle_pwm))
        else $error("PWM toggle enable gating wrong");

endmodule : wave_channel

// [design/timer8_wave_ctrl.sv]
// How it works
// - Nonzero channel A output mode routes channel A waveform onto its pin, except 1 in PWM without wave_mode_hi.
// - Output mode meaning depends on non-PWM, fast PWM or phase PWM.
// - Non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM A: 2 clears on match, sets at top; 3 inverse; 0 off.
// - PWM A value 1 toggles on match only with wave_mode_hi set.
// - Phase PWM A: 2 clears up-match, sets down-match; 3 inverse.
// - Compare A equal to top with high bit: ignore match, act at top.
// - Nonzero channel B output mode routes channel B waveform onto its pin, except 1 in PWM modes.
// - Non-PWM channel B: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM B: 2 clear/set top, 3 inverse, 1 reserved.
// - Phase PWM B: 2 clears up-match, sets down-match; 3 inverse; 1 reserved.
// - Compare B equal to top with high bit: ignore match, act at top.
// - Control A bits 3 and 2 always read zero.
// - Wave mode is three bits; 0 normal, 1/5 phase, 2 ctc, 3/7 fast.
// - Top 0xFF or compare A by mode; compare update immediate or at top.
// - Overflow set at MAX, at BOTTOM in phase modes, at top in mode 7.
// - Fast PWM counts up to top then clears to zero next clock.
// - Phase PWM counts up to top, then straight down to bottom, with no hold at top.
//
// Purpose: Timer control A decode, counter core and two waveform channels
// Assumes: Avalon-MM slave with waitrequest; timer clock is SYS_CLK
// Notes:   Every access takes two cycles; upper read data bits are zero
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module timer8_wave_ctrl (
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             WAVE_OUT_A,
    output logic             WAVE_EN_A,
    output logic             WAVE_OUT_B,
    output logic             WAVE_EN_B,
    output logic             OVERFLOW_FLAG
);

    logic       wait_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] cmp_buf_a_reg;
    logic [7:0] cmp_buf_b_reg;
    logic [7:0] cmp_act_a_reg;
    logic [7:0] cmp_act_b_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic       dir_down_reg;
    logic       dir_down_next;
    logic       ovf_reg;

    // Bus handshake
    wire        req       = AVS_READ | AVS_WRITE;
    wire        wr_commit = AVS_WRITE & ~wait_reg & AVS_BYTEENABLE[0];
    wire        rd_take   = AVS_READ & wait_reg;
    wire [7:0]  wdata     = AVS_WRITEDATA[7:0];
    wire        sel_a     = AVS_ADDRESS == timer8_pkg::ADDR_CTRL_A;
    wire        sel_b     = AVS_ADDRESS == timer8_pkg::ADDR_CTRL_B;
    wire        sel_ca    = AVS_ADDRESS == timer8_pkg::ADDR_CMP_A;
    wire        sel_cb    = AVS_ADDRESS == timer8_pkg::ADDR_CMP_B;
    wire        sel_fl    = AVS_ADDRESS == timer8_pkg::ADDR_FLAGS;

    wire timer8_pkg::wave_mode_e mode = timer8_pkg::wave_mode_e'(
        {ctrl_b_reg[timer8_pkg::WAVE_HI_BIT],
         ctrl_a_reg[timer8_pkg::WAVE_LOW_LSB +: 2]});
    wire        is_fast   = mode == timer8_pkg::WM_FAST_FF
                          | mode == timer8_pkg::WM_FAST_CMP;
    wire        is_phase  = mode == timer8_pkg::WM_PC_FF
                          | mode == timer8_pkg::WM_PC_CMP;
    wire        top_cmp   = mode == timer8_pkg::WM_CTC
                          | mode == timer8_pkg::WM_PC_CMP
                          | mode == timer8_pkg::WM_FAST_CMP;
    wire [7:0]  top       = top_cmp ? cmp_act_a_reg : timer8_pkg::COUNT_MAX;
    wire        at_top    = count_reg == top;
    wire        at_bottom = count_reg == timer8_pkg::COUNT_BOTTOM;
    wire        cmp_load  = (is_fast | is_phase) ? at_top : 1'h1;
    wire        ovf_set   = ((mode == timer8_pkg::WM_NORMAL
                            | mode == timer8_pkg::WM_CTC
                            | mode == timer8_pkg::WM_FAST_FF)
                            & count_reg == timer8_pkg::COUNT_MAX)
                          | (is_phase & at_bottom)
                          | (mode == timer8_pkg::WM_FAST_CMP & at_top);
    wire        ovf_clr   = wr_commit & sel_fl
                          & wdata[timer8_pkg::FLAG_OVF_BIT];
    wire        match_a   = count_reg == cmp_act_a_reg;
    wire        match_b   = count_reg == cmp_act_b_reg;
    wire        a_is_top  = cmp_act_a_reg == top;
    wire        b_is_top  = cmp_act_b_reg == top;

    always_comb
    begin
        if (sel_a)
            rdata_next = ctrl_a_reg & timer8_pkg::CTRL_A_WMASK;
        else if (sel_b)
            rdata_next = ctrl_b_reg & timer8_pkg::CTRL_B_WMASK;
        else if (sel_ca)
            rdata_next = cmp_buf_a_reg;
        else if (sel_cb)
            rdata_next = cmp_buf_b_reg;
        else if (AVS_ADDRESS == timer8_pkg::ADDR_COUNT)
            rdata_next = count_reg;
        else if (sel_fl)
            rdata_next = {6'h00, dir_down_reg, ovf_reg};
        else
            rdata_next = 8'h00;
    end

    always_comb
    begin
        count_next    = 8'(count_reg + 8'h01);
        dir_down_next = 1'h0;
        if (is_phase)
        begin
            dir_down_next = dir_down_reg;
            if (!dir_down_reg)
            begin
                if (at_top)
                begin
                    dir_down_next = 1'h1;
                    count_next    = at_bottom ? count_reg
                                              : 8'(count_reg - 8'h01);
                end
            end
            else if (at_bottom)
            begin
                dir_down_next = 1'h0;
                if (at_top)
                    count_next = count_reg;
            end
            else
            begin
                count_next = 8'(count_reg - 8'h01);
            end
        end
        else if (top_cmp && at_top)
        begin
            count_next = timer8_pkg::COUNT_BOTTOM;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wait_reg  <= 1'h1;
            rdata_reg <= 8'h00;
        end
        else
        begin
            wait_reg <= ~(req & wait_reg);
            if (rd_take)
                rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctrl_a_reg    <= timer8_pkg::CTRL_RST;
            ctrl_b_reg    <= timer8_pkg::CTRL_RST;
            cmp_buf_a_reg <= timer8_pkg::CMP_RST;
            cmp_buf_b_reg <= timer8_pkg::CMP_RST;
        end
        else
        begin
            if (wr_commit && sel_a)
                ctrl_a_reg <= wdata & timer8_pkg::CTRL_A_WMASK;
            if (wr_commit && sel_b)
                ctrl_b_reg <= wdata & timer8_pkg::CTRL_B_WMASK;
            if (wr_commit && sel_ca)
                cmp_buf_a_reg <= wdata;
            if (wr_commit && sel_cb)
                cmp_buf_b_reg <= wdata;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cmp_act_a_reg <= timer8_pkg::CMP_RST;
            cmp_act_b_reg <= timer8_pkg::CMP_RST;
            count_reg     <= timer8_pkg::COUNT_RST;
            dir_down_reg  <= 1'h0;
            ovf_reg       <= 1'h0;
        end
        else
        begin
            if (cmp_load)
            begin
                cmp_act_a_reg <= cmp_buf_a_reg;
                cmp_act_b_reg <= cmp_buf_b_reg;
            end
            count_reg    <= count_next;
            dir_down_reg <= dir_down_next;
            ovf_reg      <= ovf_set | (ovf_reg & ~ovf_clr);
        end
    end

    wave_channel #(
        .TOGGLE_OK (1'h1)
    ) u_chan_a (
        .clk          (SYS_CLK),
        .rst_n        (RESETN),
        .pwm_fast     (is_fast),
        .pwm_phase    (is_phase),
        .wave_mode_hi (ctrl_b_reg[timer8_pkg::WAVE_HI_BIT]),
        .out_mode     (ctrl_a_reg[timer8_pkg::OUT_A_LSB +: 2]),
        .match        (match_a),
        .at_top       (at_top),
        .dir_down     (dir_down_reg),
        .cmp_is_top   (a_is_top),
        .wave_out     (WAVE_OUT_A),
        .wave_en      (WAVE_EN_A)
    );

    wave_channel #(
        .TOGGLE_OK (1'h0)
    ) u_chan_b (
        .clk          (SYS_CLK),
        .rst_n        (RESETN),
        .pwm_fast     (is_fast),
        .pwm_phase    (is_phase),
        .wave_mode_hi (ctrl_b_reg[timer8_pkg::WAVE_HI_BIT]),
        .out_mode     (ctrl_a_reg[timer8_pkg::OUT_B_LSB +: 2]),
        .match        (match_b),
        .at_top       (at_top),
        .dir_down     (dir_down_reg),
        .cmp_is_top   (b_is_top),
        .wave_out     (WAVE_OUT_B),
        .wave_en      (WAVE_EN_B)
    );

    assign AVS_READDATA    = {24'h000000, rdata_reg};
    assign AVS_WAITREQUEST = wait_reg;
    assign OVERFLOW_FLAG   = ovf_reg;

    a_reserved_read_zero: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        rd_take && sel_a |=> AVS_READDATA[3:2] == 2'h0)
        else $error("Reserved control bits read nonzero");

    a_unused_write_drop: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        wr_commit && sel_a |=> ctrl_a_reg[3:2] == 2'h0
        && ctrl_a_reg[7:4] == $past(wdata[7:4]))
        else $error("Control write stored wrong bits");

    a_fast_wrap_zero: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        is_fast && at_top |=> count_reg == timer8_pkg::COUNT_BOTTOM)
        else $error("Fast PWM did not clear after top");

    a_phase_turn_top: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        is_phase && at_top && !dir_down_reg && !at_bottom
        |=> dir_down_reg && count_reg == 8'($past(count_reg) - 8'h01))
        else $error("Phase PWM did not turn at top");

    a_phase_turn_bot: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        is_phase && dir_down_reg && at_bottom && !at_top
        |=> !dir_down_reg ##0 count_reg == 8'h01)
        else $error("Phase PWM did not turn at bottom");

    a_ctc_clear_top: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        mode == timer8_pkg::WM_CTC && match_a
        |=> count_reg == timer8_pkg::COUNT_BOTTOM)
        else $error("Compare-clear mode missed top");

    a_cmp_immediate: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        !is_fast && !is_phase |=> cmp_act_a_reg == $past(cmp_buf_a_reg))
        else $error("Immediate compare update missed");

    a_ovf_at_max: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        (mode == timer8_pkg::WM_NORMAL || mode == timer8_pkg::WM_FAST_FF)
        && count_reg == timer8_pkg::COUNT_MAX |=> OVERFLOW_FLAG)
        else $error("Overflow not set at MAX");

    a_ovf_phase_bottom: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        is_phase && at_bottom |=> OVERFLOW_FLAG)
        else $error("Overflow not set at BOTTOM");

    a_bus_one_wait: assert property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("Bus answer not in two cycles");

    c_fast_top: cover property (
        @(posedge SYS_CLK) disable iff (!RESETN) is_fast && at_top);

    c_phase_turn: cover property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        is_phase && !dir_down_reg ##1 dir_down_reg);

    c_ovf_clear: cover property (
        @(posedge SYS_CLK) disable iff (!RESETN) ovf_reg && ovf_clr);

    c_toggle_a: cover property (
        @(posedge SYS_CLK) disable iff (!RESETN)
        WAVE_EN_A && $changed(WAVE_OUT_A));

endmodule : timer8_wave_ctrl

// [bench/port_pin_model.sv]
// Purpose: Port pad seen by one waveform output of the timer
// Assumes: Direction bit and plain port value come from the bench
// Notes:   Pad is pulled up whenever its output driver is disabled
`timescale 1ns/1ps
module port_pin_model (
    input  wire logic wave_out,
    input  wire logic wave_en,
    input  wire logic dir_out,
    input  wire logic port_val,
    output logic      pad
);
    assign pad = dir_out ? (wave_en ? wave_out : port_val) : 1'b1;
endmodule : port_pin_model

// [bench/tb_timer8_wave_ctrl.sv]
// Purpose: Self-checking bench of the timer waveform control block
// Assumes: Two-cycle Avalon access, timer counts every clock
// Notes:   Waveforms are judged by high-cycle counts over whole periods
`timescale 1ns/1ps
module tb_timer8_wave_ctrl;
    typedef struct {
        logic [7:0] ca, cb, ma, mb;
        int         win;
        bit         ch;
        int         hi;
        bit         ovf;
    } row_s;
    logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, v, w;
    logic [2:0]  m;
    logic [31:0] avs_writedata, avs_readdata, rd, hi;
    logic        wave_out_a, wave_en_a, wave_out_b, wave_en_b;
    logic        overflow_flag, dir_out, pad_a, pad_b, b, x;
    int          num_errors, n_compared, seed;
    row_s        rows [16];

    timer8_wave_ctrl i_dut (
        .SYS_CLK(sys_clk), .RESETN(resetn), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .WAVE_OUT_A(wave_out_a), .WAVE_EN_A(wave_en_a),
        .WAVE_OUT_B(wave_out_b), .WAVE_EN_B(wave_en_b),
        .OVERFLOW_FLAG(overflow_flag)
    );
    port_pin_model i_pin_a (.wave_out(wave_out_a), .wave_en(wave_en_a),
        .dir_out(dir_out), .port_val(1'b0), .pad(pad_a));
    port_pin_model i_pin_b (.wave_out(wave_out_b), .wave_en(wave_en_b),
        .dir_out(dir_out), .port_val(1'b0), .pad(pad_b));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at a rising edge
    task bus(input bit wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h000000, d};
        // Only the watchdog ends a wait that never sees waitrequest low
        do
        begin
            @(posedge sys_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    // Pin is connected unless off, or toggle in PWM on channel B or without the high bit
    function automatic logic exp_en(logic [1:0] om, logic [2:0] wm,
                                    bit is_a);
        if (om == 2'b00)
            return 1'b0;
        if (om == 2'b01 && wm[0])
            return is_a & wm[2];
        return 1'b1;
    endfunction : exp_en

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end

    initial
    begin
        rows[0]  = '{8'h40, 8'h00, 8'h10, 8'h00, 512, 1'b0, 256, 1'b1};
        rows[1]  = '{8'h80, 8'h00, 8'h10, 8'h00, 512, 1'b0, 0, 1'b1};
        rows[2]  = '{8'hc0, 8'h00, 8'h10, 8'h00, 512, 1'b0, 512, 1'b1};
        rows[3]  = '{8'h42, 8'h00, 8'h3f, 8'h00, 128, 1'b0, 64, 1'b0};
        rows[4]  = '{8'h83, 8'h00, 8'h40, 8'h00, 256, 1'b0, 65, 1'b1};
        rows[5]  = '{8'hc3, 8'h00, 8'h40, 8'h00, 256, 1'b0, 191, 1'b1};
        rows[6]  = '{8'h81, 8'h00, 8'h40, 8'h00, 510, 1'b0, 128, 1'b1};
        rows[7]  = '{8'hc1, 8'h00, 8'h40, 8'h00, 510, 1'b0, 382, 1'b1};
        rows[8]  = '{8'h23, 8'h00, 8'h00, 8'h20, 256, 1'b1, 33, 1'b1};
        rows[9]  = '{8'h31, 8'h00, 8'h00, 8'h20, 510, 1'b1, 446, 1'b1};
        rows[10] = '{8'h83, 8'h08, 8'h7f, 8'h00, 128, 1'b0, 128, 1'b1};
        rows[11] = '{8'h43, 8'h08, 8'h7f, 8'h00, 256, 1'b0, 128, 1'b1};
        rows[12] = '{8'h23, 8'h08, 8'h7f, 8'h7f, 128, 1'b1, 128, 1'b1};
        rows[13] = '{8'h21, 8'h08, 8'h7f, 8'h20, 254, 1'b1, 64, 1'b1};
        rows[14] = '{8'h80, 8'h08, 8'h10, 8'h00, 512, 1'b0, 0, 1'b0};
        rows[15] = '{8'h10, 8'h00, 8'h00, 8'h20, 512, 1'b1, 256, 1'b1};
        seed          = 76;
        num_errors    = 0;
        n_compared    = 0;
        resetn        = 1'b0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_address   = 8'h00;
        avs_writedata = 32'h00000000;
        dir_out       = 1'b1;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b0, timer8_pkg::ADDR_CTRL_A, 8'h00);
        chk("ctrl_a reset", {24'h000000, timer8_pkg::CTRL_RST}, rd);
        bus(1'b0, 8'h80, 8'h00);
        chk("unmapped read", 32'h00000000, rd);
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            bus(1'b1, timer8_pkg::ADDR_CTRL_B, w);
            bus(1'b1, timer8_pkg::ADDR_CTRL_A, v);
            bus(1'b0, timer8_pkg::ADDR_CTRL_A, 8'h00);
            chk("ctrl_a", 32'(v & timer8_pkg::CTRL_A_WMASK), rd);
            bus(1'b0, timer8_pkg::ADDR_CTRL_B, 8'h00);
            chk("ctrl_b", 32'(w & timer8_pkg::CTRL_B_WMASK), rd);
            m = {w[3], v[1:0]};
            chk("en_a", exp_en(v[7:6], m, 1'b1), wave_en_a);
            chk("en_b", exp_en(v[5:4], m, 1'b0), wave_en_b);
        end
        foreach (rows[i])
        begin
            v = rows[i].ca;
            b = rows[i].ch;
            m = {rows[i].cb[3], v[1:0]};
            bus(1'b1, timer8_pkg::ADDR_CMP_A, rows[i].ma);
            bus(1'b1, timer8_pkg::ADDR_CMP_B, rows[i].mb);
            bus(1'b1, timer8_pkg::ADDR_CTRL_B, rows[i].cb);
            bus(1'b1, timer8_pkg::ADDR_CTRL_A, v);
            repeat (600) @(posedge sys_clk);
            bus(1'b1, timer8_pkg::ADDR_FLAGS, 8'h01);
            hi = 0;
            repeat (rows[i].win)
            begin
                @(negedge sys_clk);
                hi += b ? pad_b : pad_a;
            end
            chk("high cycles", rows[i].hi, hi);
            // An event in the last window cycle sets the flag one edge later
            @(negedge sys_clk);
            chk("overflow", rows[i].ovf, overflow_flag);
            x = exp_en(b ? v[5:4] : v[7:6], m, !b);
            chk("enable", x, b ? wave_en_b : wave_en_a);
        end
        @(posedge sys_clk);
        dir_out <= 1'b0;
        @(negedge sys_clk);
        chk("pad released", 1'b1, pad_a);
        stop_test();
    end
endmodule : tb_timer8_wave_ctrl
